// ===== cea_pkg.sv
// constants and types shared by the effective address unit
package cea_pkg;

    // prefix byte values seen in front of an opcode
    localparam logic [7:0]  SECOND_INDEX_PREFIX          = 8'h90;
    localparam logic [7:0]  SECOND_INDEX_INDIRECT_PREFIX = 8'h91;
    localparam logic [7:0]  INDIRECTION_PREFIX           = 8'h92;

    // number of bytes that follow the opcode in the code stream
    localparam logic [1:0]  LEN_NONE = 2'h0;
    localparam logic [1:0]  LEN_BYTE = 2'h1;
    localparam logic [1:0]  LEN_WORD = 2'h2;

    // address limits of the short forms
    localparam logic [15:0] PAGE0_TOP = 16'h00FF;
    localparam logic [15:0] IDX_TOP   = 16'h01FE;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;

    typedef enum logic [6:0] {
        S_IDLE = 7'b000_0001,
        S_OPC  = 7'b000_0010,
        S_B1   = 7'b000_0100,
        S_B2   = 7'b000_1000,
        S_REL  = 7'b001_0000,
        S_PH   = 7'b010_0000,
        S_PL   = 7'b100_0000
    } cea_state_type;

    // addressing attributes of one decoded opcode
    typedef struct packed {
        logic [1:0] len;     // stream bytes after the opcode, not counting a bit-test offset
        logic       imm;     // byte is the operand itself
        logic       idx;     // index register is added
        logic       ind;     // stream byte is a pointer address
        logic       pword;   // pointer in memory is two bytes
        logic       bitrel;  // bit test: address then branch offset
        logic       rel;     // branch offset is produced
    } cea_attr_type;

    typedef struct packed {
        cea_state_type state;
        logic [15:0]   pc;
        logic [15:0]   pc0;
        logic [1:0]    npfx;
        logic [7:0]    opc;
        logic          pfx_y;
        logic          pfx_ind;
        cea_attr_type  attr;
        logic [15:0]   val;
        logic [7:0]    rel;
        logic          req;
        logic [15:0]   addr;
        logic          done;
        logic          busy;
        logic [15:0]   ea;
        logic [15:0]   target;
        logic [7:0]    operand;
    } cea_regs_type;

endpackage

// ===== cea_dec_if.sv
// carrier between the sequencer and the opcode classifier
`timescale 1ns/1ps
interface cea_dec_if;
    logic [7:0]            opcode;
    logic                  ind_pfx;
    logic                  y_pfx;
    cea_pkg::cea_attr_type attr;

    modport main (output opcode, output ind_pfx, output y_pfx, input attr);
    modport dec  (input opcode, input ind_pfx, input y_pfx, output attr);
endinterface

// ===== cea_mode_dec.sv
// opcode classifier: addressing attributes from the high opcode nibble
`timescale 1ns/1ps
module cea_mode_dec
    import cea_pkg::*;
(
    cea_dec_if.dec d
);

    cea_attr_type a;

    // short forms take one stream byte, long forms two; the indirection
    // prefix turns direct and offset-indexed forms into their pointer forms
    always_comb begin
        a = '0;
        case (d.opcode[7:4])
            4'h0: begin
                a.len    = LEN_BYTE;
                a.bitrel = 1'b1;
                a.ind    = d.ind_pfx;
            end
            4'h1, 4'h3, 4'hB: begin
                a.len = LEN_BYTE;
                a.ind = d.ind_pfx;
            end
            4'h2: begin
                a.len = LEN_BYTE;
                a.rel = 1'b1;
                a.ind = d.ind_pfx;
            end
            4'h6, 4'hE: begin
                a.len = LEN_BYTE;
                a.idx = 1'b1;
                a.ind = d.ind_pfx;
            end
            4'h7, 4'hF: begin
                a.idx = 1'b1;
            end
            4'hA: begin
                a.len = LEN_BYTE;
                a.imm = 1'b1;
            end
            4'hC, 4'hD: begin
                a.idx   = d.opcode[4];
                a.ind   = d.ind_pfx;
                a.pword = d.ind_pfx;
                a.len   = d.ind_pfx ? LEN_BYTE : LEN_WORD;
            end
            default: begin
                a.len = LEN_NONE;
            end
        endcase
    end

    assign d.attr = a;

endmodule

// ===== cea_addr_unit.sv
// operand fetch and effective address sequencer
`timescale 1ns/1ps
module cea_addr_unit
    import cea_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic [15:0] pc_i,
    input  wire logic [7:0]  x_i,
    input  wire logic [7:0]  y_i,
    output logic             mem_req_o,
    output logic [15:0]      mem_addr_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       opcode_o,
    output cea_attr_type     attr_o,
    output logic             use_y_o,
    output logic [7:0]       operand_o,
    output logic [15:0]      ea_o,
    output logic [15:0]      target_o,
    output logic [15:0]      next_pc_o
);

    cea_regs_type r_reg;
    cea_regs_type r_next;
    cea_dec_if    dif ();

    cea_mode_dec u_dec (
        .d (dif.dec)
    );

    // the classifier looks at the byte on the bus during the opcode fetch
    assign dif.opcode  = mem_rdata_i;
    assign dif.ind_pfx = r_reg.pfx_ind;
    assign dif.y_pfx   = r_reg.pfx_y;

    // close a sequence: index sum keeps the carry, offset is sign-extended
    function automatic cea_regs_type finish(input cea_regs_type s,
                                            input logic [7:0]   xv,
                                            input logic [7:0]   yv);
        logic [7:0] ix;
        ix       = s.pfx_y ? yv : xv;
        s.ea     = s.attr.idx ? s.val + {ZERO_BYTE, ix}
                              : s.val;
        s.target = s.pc + {{8{s.rel[7]}}, s.rel};
        s.operand = s.val[7:0];
        s.state  = S_IDLE;
        s.req    = 1'b0;
        s.busy   = 1'b0;
        s.done   = 1'b1;
        return s;
    endfunction

    // sequencer: one bus byte per acknowledged request
    always_comb begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        case (r_reg.state)
            S_IDLE: begin
                if (start_i) begin
                    r_next.state   = S_OPC;
                    r_next.pc      = pc_i;
                    r_next.pc0     = pc_i;
                    r_next.npfx    = 2'h0;
                    r_next.addr    = pc_i;
                    r_next.req     = 1'b1;
                    r_next.busy    = 1'b1;
                    r_next.pfx_y   = 1'b0;
                    r_next.pfx_ind = 1'b0;
                    r_next.val     = 16'h0000;
                    r_next.rel     = 8'h00;
                end
            end
            S_OPC: begin
                if (mem_ack_i) begin
                    r_next.pc   = r_reg.pc + 16'h0001;
                    r_next.addr = r_reg.pc + 16'h0001;
                    if (mem_rdata_i == SECOND_INDEX_PREFIX) begin
                        r_next.pfx_y = 1'b1;
                        r_next.npfx  = r_reg.npfx + 2'h1;
                    end else if (mem_rdata_i == INDIRECTION_PREFIX) begin
                        r_next.pfx_ind = 1'b1;
                        r_next.npfx    = r_reg.npfx + 2'h1;
                    end else if (mem_rdata_i ==
                                 SECOND_INDEX_INDIRECT_PREFIX) begin
                        r_next.pfx_y   = 1'b1;
                        r_next.pfx_ind = 1'b1;
                        r_next.npfx    = r_reg.npfx + 2'h1;
                    end else begin
                        r_next.opc  = mem_rdata_i;
                        r_next.attr = dif.attr;
                        if (dif.attr.len == LEN_NONE) begin
                            r_next = finish(r_next, x_i, y_i);
                        end else begin
                            r_next.state = S_B1;
                        end
                    end
                end
            end
            S_B1: begin
                if (mem_ack_i) begin
                    r_next.pc   = r_reg.pc + 16'h0001;
                    r_next.addr = r_reg.pc + 16'h0001;
                    r_next.val  = {ZERO_BYTE, mem_rdata_i};
                    if (r_reg.attr.len == LEN_WORD) begin
                        r_next.state = S_B2;
                    end else if (r_reg.attr.bitrel) begin
                        r_next.state = S_REL;
                    end else if (r_reg.attr.ind) begin
                        r_next.state = S_PH;
                        r_next.addr  = {ZERO_BYTE, mem_rdata_i};
                    end else if (r_reg.attr.rel) begin
                        r_next.rel = mem_rdata_i;
                        r_next     = finish(r_next, x_i, y_i);
                    end else begin
                        r_next = finish(r_next, x_i, y_i);
                    end
                end
            end
            S_B2: begin
                if (mem_ack_i) begin
                    r_next.pc  = r_reg.pc + 16'h0001;
                    r_next.val = {r_reg.val[7:0], mem_rdata_i};
                    r_next     = finish(r_next, x_i, y_i);
                end
            end
            S_REL: begin
                if (mem_ack_i) begin
                    r_next.pc  = r_reg.pc + 16'h0001;
                    r_next.rel = mem_rdata_i;
                    if (r_reg.attr.ind) begin
                        r_next.state = S_PH;
                        r_next.addr  = {ZERO_BYTE, r_reg.val[7:0]};
                    end else begin
                        r_next = finish(r_next, x_i, y_i);
                    end
                end
            end
            S_PH: begin
                if (mem_ack_i) begin
                    if (r_reg.attr.pword) begin
                        // pointer at FF takes its low byte from 0100
                        r_next.val   = {ZERO_BYTE, mem_rdata_i};
                        r_next.addr  = r_reg.addr + 16'h0001;
                        r_next.state = S_PL;
                    end else if (r_reg.attr.rel && !r_reg.attr.bitrel) begin
                        r_next.rel = mem_rdata_i;
                        r_next     = finish(r_next, x_i, y_i);
                    end else begin
                        r_next.val = {ZERO_BYTE, mem_rdata_i};
                        r_next     = finish(r_next, x_i, y_i);
                    end
                end
            end
            S_PL: begin
                if (mem_ack_i) begin
                    r_next.val = {r_reg.val[7:0], mem_rdata_i};
                    r_next     = finish(r_next, x_i, y_i);
                end
            end
            default: begin
                r_next       = '0;
                r_next.state = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            r_reg       <= '0;
            r_reg.state <= S_IDLE;
        end else begin
            r_reg <= r_next;
        end
    end

    // every output is a field of the state register
    assign mem_req_o  = r_reg.req;
    assign mem_addr_o = r_reg.addr;
    assign busy_o     = r_reg.busy;
    assign done_o     = r_reg.done;
    assign opcode_o   = r_reg.opc;
    assign attr_o     = r_reg.attr;
    assign use_y_o    = r_reg.pfx_y;
    assign operand_o  = r_reg.operand;
    assign ea_o       = r_reg.ea;
    assign target_o   = r_reg.target;
    assign next_pc_o  = r_reg.pc;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    inh_no_bytes_a: assert property (done_o
        && attr_o.len == LEN_NONE
        |-> next_pc_o == r_reg.pc0 + {14'h0000, r_reg.npfx} + 16'h0001)
        else $error("inherent opcode consumed stream bytes");
    imm_operand_a: assert property (done_o && attr_o.imm
        |-> operand_o == $past(mem_rdata_i)
            && next_pc_o == r_reg.pc0 + {14'h0000, r_reg.npfx} + 16'h0002)
        else $error("immediate operand or length wrong");
    short_page_a: assert property (done_o && !attr_o.idx
        && attr_o.len == LEN_BYTE && !attr_o.imm && !attr_o.rel
        && !(attr_o.ind && attr_o.pword) |-> ea_o <= PAGE0_TOP)
        else $error("short form left page zero");
    long_order_a: assert property (done_o && attr_o.len == LEN_WORD
        |-> ea_o[7:0] == $past(mem_rdata_i) + (attr_o.idx ? (use_y_o ?
            $past(y_i) : $past(x_i)) : ZERO_BYTE)
            && next_pc_o == r_reg.pc0 + {14'h0000, r_reg.npfx} + 16'h0003)
        else $error("long form byte order or length wrong");
    noofs_index_a: assert property (done_o && attr_o.idx
        && attr_o.len == LEN_NONE
        |-> ea_o == {ZERO_BYTE, use_y_o ? $past(y_i) : $past(x_i)})
        else $error("no-offset indexed address is not the index");
    short_idx_a: assert property (done_o && attr_o.idx
        && attr_o.len == LEN_BYTE && !attr_o.pword |-> ea_o <= IDX_TOP)
        else $error("short indexed address above 1FE");
    ptr_page_a: assert property (r_reg.state == S_PH
        |-> mem_addr_o <= PAGE0_TOP && mem_req_o)
        else $error("pointer address outside page zero");
    short_ind_a: assert property (done_o && attr_o.ind
        && !attr_o.pword && !attr_o.idx && !attr_o.rel
        |-> ea_o == {ZERO_BYTE, $past(mem_rdata_i)})
        else $error("short indirect address is not the pointer");
    rmw_short_a: assert property (done_o
        && (opcode_o[7:4] == 4'h3 || opcode_o[7:4] == 4'h6
            || opcode_o[7:4] == 4'h7) |-> attr_o.len != LEN_WORD)
        else $error("read-modify-write decoded with a long form");
    rel_target_a: assert property (done_o && attr_o.rel
        && !attr_o.ind
        |-> target_o == next_pc_o + {{8{$past(mem_rdata_i[7])}},
                                     $past(mem_rdata_i)})
        else $error("relative branch target wrong");
    y_prefix_a: assert property (r_reg.state == S_OPC && mem_ack_i
        && mem_rdata_i == SECOND_INDEX_PREFIX |=> use_y_o && busy_o)
        else $error("second index prefix not recorded");

    inh_c:   cover property (done_o && attr_o.len == LEN_NONE);
    imm_c:   cover property (done_o && attr_o.imm);
    lind_c:  cover property (done_o && attr_o.pword && attr_o.idx);
    brel_c:  cover property (done_o && attr_o.bitrel && attr_o.ind);

endmodule

// ===== cpu_effective_address_unit_bench.sv
// self-checking bench for the effective address sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end

module cpu_effective_address_unit_bench
    import cea_pkg::*;
();
    // one expected result; len 3 means the length field is not compared
    typedef struct packed {
        logic [7:0]  opc;
        logic [15:0] npc;
        logic [15:0] val;
        logic [1:0]  kind;   // 0 none, 1 ea, 2 operand, 3 target
        logic        use_y;
        logic [3:0]  acks;
        logic [1:0]  len;
    } cea_bench_exp_type;

    logic               core_clk_i  = 1'b0;
    logic               rst_i       = 1'b1;
    logic               start_i     = 1'b0;
    logic [15:0]        pc_i        = 16'h0000;
    logic [7:0]         x_i         = 8'h00;
    logic [7:0]         y_i         = 8'h00;
    logic               mem_ack_i   = 1'b0;
    logic [7:0]         mem_rdata_i = 8'h00;
    logic               mem_req_o;
    logic [15:0]        mem_addr_o;
    logic               busy_o;
    logic               done_o;
    logic [7:0]         opcode_o;
    cea_attr_type       attr_o;
    logic               use_y_o;
    logic [7:0]         operand_o;
    logic [15:0]        ea_o;
    logic [15:0]        target_o;
    logic [15:0]        next_pc_o;
    logic [7:0]         mem [0:65535];
    logic [31:0]        stall_lfsr  = 32'h0001_7717;
    logic [31:0]        data_lfsr   = 32'h0001_7717;
    logic [3:0]         acks        = 4'h0;
    int                 err_total   = 0;
    int                 check_count = 0;
    cea_bench_exp_type  expq [$];

    cea_addr_unit dut (
        .core_clk_i  (core_clk_i),
        .rst_i       (rst_i),
        .start_i     (start_i),
        .pc_i        (pc_i),
        .x_i         (x_i),
        .y_i         (y_i),
        .mem_req_o   (mem_req_o),
        .mem_addr_o  (mem_addr_o),
        .mem_ack_i   (mem_ack_i),
        .mem_rdata_i (mem_rdata_i),
        .busy_o      (busy_o),
        .done_o      (done_o),
        .opcode_o    (opcode_o),
        .attr_o      (attr_o),
        .use_y_o     (use_y_o),
        .operand_o   (operand_o),
        .ea_o        (ea_o),
        .target_o    (target_o),
        .next_pc_o   (next_pc_o)
    );

    // 200 MHz core clock
    always #2.5 core_clk_i = ~core_clk_i;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // memory answers with random stalls; idle data is scrambled so a
    // byte taken without ack never looks right
    always @(negedge core_clk_i) begin
        stall_lfsr = lfsr_next(stall_lfsr);
        if (mem_req_o === 1'b1 && stall_lfsr[3]) begin
            mem_ack_i   = 1'b1;
            mem_rdata_i = mem[mem_addr_o];
        end else begin
            mem_ack_i   = 1'b0;
            mem_rdata_i = ~mem_rdata_i;
        end
    end

    // watcher: counts taken bytes and checks each result against the note
    always @(posedge core_clk_i) begin
        cea_bench_exp_type e;
        if (!rst_i && mem_req_o === 1'b1 && mem_ack_i) begin
            acks <= acks + 4'h1;
        end
        if (!rst_i && done_o === 1'b1) begin
            acks <= 4'h0;
            if (expq.size() == 0) begin
                err_total++;
                $display("mismatch at %0t: unexpected done", $time);
            end else begin
                e = expq.pop_front();
                `CHK(opcode_o, e.opc)
                `CHK(next_pc_o, e.npc)
                `CHK(acks, e.acks)
                `CHK(use_y_o, e.use_y)
                if (e.len != 2'h3) `CHK(attr_o.len, e.len)
                if (e.kind == 2'h1) `CHK(ea_o, e.val)
                if (e.kind == 2'h2) `CHK(operand_o, e.val[7:0])
                if (e.kind == 2'h3) `CHK(target_o, e.val)
            end
        end
    end

    // start holds for a second cycle with a bad pc: that one is refused
    task automatic run_case(input logic [15:0] pc, input logic [31:0] code,
                            input logic [7:0] xv, input logic [7:0] yv,
                            input cea_bench_exp_type e);
        int n;
        for (int i = 0; i < 4; i++) begin
            mem[pc + 16'(i)] = code[31 - 8 * i -: 8];
        end
        n = 0;
        @(negedge core_clk_i);
        while (busy_o !== 1'b0 && n < 100) begin
            @(negedge core_clk_i);
            n++;
        end
        // a unit that never goes idle is a failure, not a silent skip
        if (n >= 100) begin
            err_total++;
            $display("mismatch at %0t: still busy", $time);
            complete_run();
        end
        expq.push_back(e);
        x_i     = xv;
        y_i     = yv;
        pc_i    = pc;
        start_i = 1'b1;
        @(negedge core_clk_i);
        pc_i = 16'hFFFF;
        @(negedge core_clk_i);
        start_i = 1'b0;
        n = 0;
        while (expq.size() != 0 && n < 200) begin
            @(negedge core_clk_i);
            n++;
        end
        if (n >= 200 || expq.size() != 0) begin
            err_total++;
            $display("mismatch at %0t: no done", $time);
            complete_run();
        end
    endtask

    initial begin
        logic [15:0] rpc;
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_i = 1'b0;
        `CHK(busy_o, 1'b0)
        `CHK(mem_req_o, 1'b0)
        `CHK(done_o, 1'b0)
        // pointers in page zero, some at the page edge
        mem[16'h0020] = 8'h55;
        mem[16'h00FF] = 8'hAB;
        mem[16'h0100] = 8'hCD;
        mem[16'h0010] = 8'hFF;
        mem[16'h0030] = 8'h12;
        mem[16'h0031] = 8'h34;
        mem[16'h0040] = 8'h77;
        run_case(16'h1000, 32'h9D00_0000, 8'h00, 8'h00,
                 '{8'h9D, 16'h1001, 16'h0000, 2'h0, 1'b0, 4'h1, LEN_NONE});
        run_case(16'h1010, 32'hA655_0000, 8'h00, 8'h00,
                 '{8'hA6, 16'h1012, 16'h0055, 2'h2, 1'b0, 4'h2, LEN_BYTE});
        run_case(16'h1020, 32'hB6F0_0000, 8'h00, 8'h00,
                 '{8'hB6, 16'h1022, 16'h00F0, 2'h1, 1'b0, 4'h2, LEN_BYTE});
        run_case(16'h1030, 32'hC612_3400, 8'h00, 8'h00,
                 '{8'hC6, 16'h1033, 16'h1234, 2'h1, 1'b0, 4'h3, LEN_WORD});
        run_case(16'h1040, 32'hF600_0000, 8'hC3, 8'h00,
                 '{8'hF6, 16'h1041, 16'h00C3, 2'h1, 1'b0, 4'h1, LEN_NONE});
        run_case(16'h1050, 32'hE6FF_0000, 8'hFF, 8'h00,
                 '{8'hE6, 16'h1052, 16'h01FE, 2'h1, 1'b0, 4'h2, LEN_BYTE});
        run_case(16'h1060, 32'hD6FF_8000, 8'h90, 8'h00,
                 '{8'hD6, 16'h1063, 16'h0010, 2'h1, 1'b0, 4'h3, LEN_WORD});
        run_case(16'h1070, 32'h92B6_2000, 8'h00, 8'h00,
                 '{8'hB6, 16'h1073, 16'h0055, 2'h1, 1'b0, 4'h4, LEN_BYTE});
        run_case(16'h1080, 32'h92C6_FF00, 8'h00, 8'h00,
                 '{8'hC6, 16'h1083, 16'hABCD, 2'h1, 1'b0, 4'h5, LEN_BYTE});
        run_case(16'h1090, 32'h92E6_1000, 8'hFF, 8'h00,
                 '{8'hE6, 16'h1093, 16'h01FE, 2'h1, 1'b0, 4'h4, LEN_BYTE});
        run_case(16'h10A0, 32'h91D6_3000, 8'h00, 8'h05,
                 '{8'hD6, 16'h10A3, 16'h1239, 2'h1, 1'b1, 4'h5, LEN_BYTE});
        run_case(16'h10B0, 32'h90F6_0000, 8'h11, 8'h77,
                 '{8'hF6, 16'h10B2, 16'h0077, 2'h1, 1'b1, 4'h2, LEN_NONE});
        run_case(16'h10C0, 32'h20FE_0000, 8'h00, 8'h00,
                 '{8'h20, 16'h10C2, 16'h10C0, 2'h3, 1'b0, 4'h2, LEN_BYTE});
        run_case(16'h10D0, 32'h923C_4000, 8'h00, 8'h00,
                 '{8'h3C, 16'h10D3, 16'h0077, 2'h1, 1'b0, 4'h4, LEN_BYTE});
        run_case(16'h10E0, 32'h90E6_8000, 8'h00, 8'h80,
                 '{8'hE6, 16'h10E3, 16'h0100, 2'h1, 1'b1, 4'h3, LEN_BYTE});
        run_case(16'h10F0, 32'h0040_0500, 8'h00, 8'h00,
                 '{8'h00, 16'h10F3, 16'h10F8, 2'h3, 1'b0, 4'h3, 2'h3});
        // bit test through a pointer: address byte, offset, pointer read
        run_case(16'h1200, 32'h9201_4003, 8'h00, 8'h00,
                 '{8'h01, 16'h1204, 16'h1207, 2'h3, 1'b0, 4'h5, LEN_BYTE});
        // relative indirect: the pointer byte is the branch offset
        run_case(16'h1210, 32'h9222_4000, 8'h00, 8'h00,
                 '{8'h22, 16'h1213, 16'h128A, 2'h3, 1'b0, 4'h4, LEN_BYTE});
        run_case(16'h1220, 32'h1250_0000, 8'h00, 8'h00,
                 '{8'h12, 16'h1222, 16'h0050, 2'h1, 1'b0, 4'h2, LEN_BYTE});
        run_case(16'h1230, 32'h90D6_1000, 8'h00, 8'h20,
                 '{8'hD6, 16'h1234, 16'h1020, 2'h1, 1'b1, 4'h4, LEN_WORD});
        // random offsets and index values on the short indexed form
        for (int i = 0; i < 8; i++) begin
            data_lfsr = lfsr_next(data_lfsr);
            rpc = 16'h1100 + 16'(i * 4);
            run_case(rpc, {8'hE6, data_lfsr[7:0], 16'h0000},
                     data_lfsr[15:8], 8'h00,
                     '{8'hE6, rpc + 16'h0002,
                       {8'h00, data_lfsr[7:0]} + {8'h00, data_lfsr[15:8]},
                       2'h1, 1'b0, 4'h2, LEN_BYTE});
        end
        complete_run();
    end
endmodule
